// *** core/kemu_regs.sv ***
// legacy keyboard emulation input, output and status registers
// assumes io and operational accesses are synchronous one-cycle strobes
//
// Operation
// RULE1: while enabled, port 60h/64h writes load the input byte.
// RULE2: operational access to input byte only moves data, nothing else.
// RULE3: input byte in bits 7..0, bits 31..8 reserved, read zero.
// RULE4: enabled port 60h read returns the stored output byte.
// RULE5: port 60h read clears output-pending status bit 0; a same-cycle software status write sets bit 0 from its data instead.
// RULE6: enabled port 64h read returns the status byte.
// RULE7: operational status access has no port side effects.
// RULE8: port 60h write clears bit 3, port 64h write sets it.
// RULE9: port writes set input-pending bit 1, except gate a20 data.
// RULE10: emulation interrupt while input-pending and enabled.
// RULE11: emulation interrupt while output-pending clear and character-pending enabled.
// RULE12: mouse line when aux-pending, output-pending and irq enable all set.
// RULE13: with irq enable, aux-pending selects keyboard or mouse line.
// RULE14: keyboard line when irq enable, output-pending set, aux-pending clear.
// RULE15: status bit 7 parity error, read-write.
// RULE16: status bit 6 time-out, read-write.
// RULE17: status bit 4 follows keyboard inhibit state, 1 means active.
// RULE18: status bit 2 plain read-write software flag.
// RULE19: software writes zero into reserved bits 31..8.
// RULE20: port decoding only while emulation enable is set.
// RULE21: gate a20 flag set by D1h to 64h, cleared by others.
// RULE22: data write during gate a20 sequence loads byte, keeps input-pending.
// RULE23: all fields reset to zero; emulation interrupt ORs both conditions.
`timescale 1ns/1ps

module kemu_regs (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // host legacy i/o port access
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [15:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata_q,
    // operational register access
    input wire logic mm_wr,
    input wire logic mm_rd,
    input wire logic [11:0] mm_addr,
    input wire logic [31:0] mm_wdata,
    output logic [31:0] mm_rdata_q,
    // control word bits held elsewhere
    input wire logic emulation_enable_bit,
    input wire logic char_pending_enable,
    input wire logic legacy_irq_enable,
    input wire logic keyboard_inhibit_state,
    // status and interrupts
    output logic gate_a20_sequence_flag_q,
    output logic emu_irq_q,
    output logic keyboard_interrupt_line_q,
    output logic mouse_interrupt_line_q
);
    // ==========================================================
    // state
    logic [7:0] in_q;
    logic [7:0] in_d;
    logic [7:0] out_q;
    logic [7:0] out_d;
    logic [7:0] stat_q;
    logic [7:0] stat_d;
    logic gate_a20_sequence_flag_d;
    logic [7:0] io_rdata_d;
    logic [31:0] mm_rdata_d;
    logic mm_stat_wr;

    kemu_port_if evt ();

    // ==========================================================
    // port decoder
    kemu_port_decode u_decode (
        .io_wr(io_wr),
        .io_rd(io_rd),
        .io_addr(io_addr),
        .io_wdata(io_wdata),
        .emulation_enable_bit(emulation_enable_bit),
        .evt(evt.src)
    );

    // ==========================================================
    // next state: software writes first, port effects override, except the data port read's bit 0 clear
    always_comb begin
        in_d = in_q;
        out_d = out_q;
        stat_d = stat_q;
        gate_a20_sequence_flag_d = gate_a20_sequence_flag_q;
        io_rdata_d = kemu_pkg::KEMU_BYTE_RST;
        mm_rdata_d = kemu_pkg::KEMU_WORD_RST;
        mm_stat_wr = mm_wr && (mm_addr == kemu_pkg::KEMU_OFF_STATUS);

        // operational writes: plain storage, reserved bits dropped
        if (mm_wr && mm_addr == kemu_pkg::KEMU_OFF_INPUT) begin
            in_d = mm_wdata[7:0]; // see RULE2 see RULE3
        end else if (mm_wr && mm_addr == kemu_pkg::KEMU_OFF_OUTPUT) begin
            out_d = mm_wdata[7:0];
        end else if (mm_stat_wr) begin
            stat_d = mm_wdata[7:0]; // see RULE7 see RULE15 see RULE16 see RULE18
        end

        // operational reads; unmapped offsets read zero
        if (mm_rd && mm_addr == kemu_pkg::KEMU_OFF_INPUT) begin
            mm_rdata_d = {kemu_pkg::KEMU_RSVD_RD, in_q}; // see RULE3
        end else if (mm_rd && mm_addr == kemu_pkg::KEMU_OFF_OUTPUT) begin
            mm_rdata_d = {kemu_pkg::KEMU_RSVD_RD, out_q};
        end else if (mm_rd && mm_addr == kemu_pkg::KEMU_OFF_STATUS) begin
            mm_rdata_d = {kemu_pkg::KEMU_RSVD_RD, stat_q};
        end

        // data port write
        if (evt.wr_data_port) begin
            in_d = evt.wr_byte; // see RULE1 see RULE22
            stat_d[kemu_pkg::KEMU_ST_CMD_DATA] = 1'b0; // see RULE8
            if (!gate_a20_sequence_flag_q) begin
                stat_d[kemu_pkg::KEMU_ST_IN_FULL] = 1'b1; // see RULE9 see RULE22
            end
        end

        // command port write
        if (evt.wr_cmd_port) begin
            in_d = evt.wr_byte; // see RULE1
            stat_d[kemu_pkg::KEMU_ST_CMD_DATA] = 1'b1; // see RULE8
            stat_d[kemu_pkg::KEMU_ST_IN_FULL] = 1'b1; // see RULE9
            gate_a20_sequence_flag_d = (evt.wr_byte == kemu_pkg::KEMU_CMD_GATE_A20); // see RULE21
        end

        // data port read; a same-cycle software status write keeps its byte
        if (evt.rd_data_port) begin
            io_rdata_d = out_q; // see RULE4
            if (!mm_stat_wr) begin
                stat_d[kemu_pkg::KEMU_ST_OUT_FULL] = 1'b0; // see RULE5
            end
        end

        // status port read
        if (evt.rd_cmd_port) begin
            io_rdata_d = stat_q; // see RULE6
        end

        // inhibit bit mirrors the switch, software writes do not stick
        stat_d[kemu_pkg::KEMU_ST_INHIBIT] = keyboard_inhibit_state; // see RULE17
    end

    // ==========================================================
    // registers, all cleared by reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            in_q <= kemu_pkg::KEMU_BYTE_RST; // see RULE23
            out_q <= kemu_pkg::KEMU_BYTE_RST;
            stat_q <= kemu_pkg::KEMU_BYTE_RST;
            gate_a20_sequence_flag_q <= 1'b0;
            io_rdata_q <= kemu_pkg::KEMU_BYTE_RST;
            mm_rdata_q <= kemu_pkg::KEMU_WORD_RST;
        end else begin
            in_q <= in_d;
            out_q <= out_d;
            stat_q <= stat_d;
            gate_a20_sequence_flag_q <= gate_a20_sequence_flag_d;
            io_rdata_q <= io_rdata_d;
            mm_rdata_q <= mm_rdata_d;
        end
    end

    // ==========================================================
    // interrupt generation
    kemu_irq_gen u_irq (
        .clk(clk),
        .sys_rst(sys_rst),
        .emulation_enable_bit(emulation_enable_bit),
        .char_pending_enable(char_pending_enable),
        .legacy_irq_enable(legacy_irq_enable),
        .in_full(stat_q[kemu_pkg::KEMU_ST_IN_FULL]),
        .out_full(stat_q[kemu_pkg::KEMU_ST_OUT_FULL]),
        .aux_full(stat_q[kemu_pkg::KEMU_ST_AUX_FULL]),
        .emu_irq_q(emu_irq_q),
        .keyboard_interrupt_line_q(keyboard_interrupt_line_q),
        .mouse_interrupt_line_q(mouse_interrupt_line_q)
    );

    // ==========================================================
    // checks
    in_capture_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE1
        (emulation_enable_bit && io_wr && (io_addr == kemu_pkg::KEMU_PORT_DATA
            || io_addr == kemu_pkg::KEMU_PORT_CMD)) |=> (in_q == $past(io_wdata)))
        else $error("port write byte not captured");

    mm_no_effect_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE2
        (mm_rd && !io_wr && !io_rd && !mm_wr && $stable(keyboard_inhibit_state))
            |=> ($stable(stat_q) && $stable(in_q) && $stable(gate_a20_sequence_flag_q)))
        else $error("operational read disturbed emulation state");

    rsvd_zero_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE3
        mm_rdata_q[31:8] == kemu_pkg::KEMU_RSVD_RD)
        else $error("reserved bits read nonzero");

    out_return_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE4
        (emulation_enable_bit && io_rd && !io_wr && io_addr == kemu_pkg::KEMU_PORT_DATA)
            |=> (io_rdata_q == $past(out_q)))
        else $error("data port read returned wrong byte");

    out_clear_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE5
        (emulation_enable_bit && io_rd && !io_wr && !mm_wr && io_addr == kemu_pkg::KEMU_PORT_DATA)
            |=> !stat_q[kemu_pkg::KEMU_ST_OUT_FULL])
        else $error("output pending not cleared by data port read");

    stat_return_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE6
        (emulation_enable_bit && io_rd && !io_wr && io_addr == kemu_pkg::KEMU_PORT_CMD)
            |=> (io_rdata_q == $past(stat_q)))
        else $error("status port read returned wrong byte");

    cmd_bit_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE8
        (emulation_enable_bit && io_wr && io_addr == kemu_pkg::KEMU_PORT_CMD)
            |=> stat_q[kemu_pkg::KEMU_ST_CMD_DATA] ##1 1'b1)
        else $error("command bit not set by command port write");

    in_full_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE9
        (emulation_enable_bit && io_wr && io_addr == kemu_pkg::KEMU_PORT_CMD)
            |=> stat_q[kemu_pkg::KEMU_ST_IN_FULL])
        else $error("input pending not set by port write");

    disabled_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE20
        (!emulation_enable_bit && !mm_wr) |=> ($stable(in_q) && io_rdata_q == 8'h00))
        else $error("port access decoded while emulation disabled");

    ga20_flag_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE21
        (emulation_enable_bit && io_wr && io_addr == kemu_pkg::KEMU_PORT_CMD)
            |=> (gate_a20_sequence_flag_q == ($past(io_wdata) == kemu_pkg::KEMU_CMD_GATE_A20)))
        else $error("gate a20 flag wrong after command write");

    ga20_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE22
        (emulation_enable_bit && io_wr && io_addr == kemu_pkg::KEMU_PORT_DATA
            && gate_a20_sequence_flag_q && !mm_wr && !stat_q[kemu_pkg::KEMU_ST_IN_FULL])
            |=> !stat_q[kemu_pkg::KEMU_ST_IN_FULL])
        else $error("input pending set during gate a20 sequence");

    // a data write drops the command marker
    data_cmd_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE8
        evt.wr_data_port
            |=> !stat_q[kemu_pkg::KEMU_ST_CMD_DATA])
        else $error("command bit not cleared by data port write");

    // outside the a20 sequence a data write marks input pending
    data_full_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE9
        (evt.wr_data_port && !gate_a20_sequence_flag_q)
            |=> stat_q[kemu_pkg::KEMU_ST_IN_FULL])
        else $error("input pending not set by data port write");

    // switch copy lags one cycle
    inhibit_copy_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE17
        1'b1
            |=> (stat_q[kemu_pkg::KEMU_ST_INHIBIT] == $past(keyboard_inhibit_state)))
        else $error("inhibit bit does not follow the switch");

    // parity bit is plain software storage
    parity_wr_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE15
        mm_stat_wr
            |=> (stat_q[kemu_pkg::KEMU_ST_PARITY] == $past(mm_wdata[kemu_pkg::KEMU_ST_PARITY])))
        else $error("parity bit write lost");

    // time-out bit is plain software storage
    timeout_wr_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE16
        mm_stat_wr
            |=> (stat_q[kemu_pkg::KEMU_ST_TIMEOUT] == $past(mm_wdata[kemu_pkg::KEMU_ST_TIMEOUT])))
        else $error("time-out bit write lost");

    // boot flag is plain software storage
    flag_wr_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE18
        mm_stat_wr
            |=> (stat_q[kemu_pkg::KEMU_ST_FLAG] == $past(mm_wdata[kemu_pkg::KEMU_ST_FLAG])))
        else $error("flag bit write lost");

    // only a software write moves the software-owned bits
    soft_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE7
        !mm_stat_wr
            |=> ($stable(stat_q[kemu_pkg::KEMU_ST_PARITY:kemu_pkg::KEMU_ST_AUX_FULL])
                && $stable(stat_q[kemu_pkg::KEMU_ST_FLAG])))
        else $error("software status bits moved without a write");

    // a software input write touches nothing but the byte
    mm_in_wr_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE2
        (mm_wr && mm_addr == kemu_pkg::KEMU_OFF_INPUT && !io_wr && !io_rd)
            |=> ($stable(stat_q[kemu_pkg::KEMU_ST_CMD_DATA:0]) && $stable(gate_a20_sequence_flag_q)))
        else $error("input write disturbed emulation state");

    // port traffic never alters the output byte
    out_keep_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE4
        !(mm_wr && mm_addr == kemu_pkg::KEMU_OFF_OUTPUT)
            |=> $stable(out_q))
        else $error("output byte changed without a software write");

    // read data falls to zero when no port read was decoded
    io_idle_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE20
        !(evt.rd_data_port || evt.rd_cmd_port)
            |=> (io_rdata_q == kemu_pkg::KEMU_BYTE_RST))
        else $error("port read data without a decoded read");

    // the emulation interrupt is exactly the or of its two causes
    irq_or_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE23
        1'b1 |=> (emu_irq_q == $past((stat_q[kemu_pkg::KEMU_ST_IN_FULL] && emulation_enable_bit)
            || (!stat_q[kemu_pkg::KEMU_ST_OUT_FULL] && char_pending_enable))))
        else $error("emulation interrupt is not the or of its causes");
endmodule

// *** core/kemu_pkg.sv ***
// constants shared by the legacy keyboard emulation register block
// assumes byte-wide legacy port data and a 12-bit operational offset bus
package kemu_pkg;

    // ==========================================================
    // operational register byte offsets
    localparam logic [11:0] KEMU_OFF_INPUT = 12'h104;
    localparam logic [11:0] KEMU_OFF_OUTPUT = 12'h108;
    localparam logic [11:0] KEMU_OFF_STATUS = 12'h10c;

    // ==========================================================
    // legacy i/o port addresses and the gate a20 command byte
    localparam logic [15:0] KEMU_PORT_DATA = 16'h0060;
    localparam logic [15:0] KEMU_PORT_CMD = 16'h0064;
    localparam logic [7:0] KEMU_CMD_GATE_A20 = 8'hd1;

    // ==========================================================
    // status byte field positions
    localparam int KEMU_ST_OUT_FULL = 0;
    localparam int KEMU_ST_IN_FULL = 1;
    localparam int KEMU_ST_FLAG = 2;
    localparam int KEMU_ST_CMD_DATA = 3;
    localparam int KEMU_ST_INHIBIT = 4;
    localparam int KEMU_ST_AUX_FULL = 5;
    localparam int KEMU_ST_TIMEOUT = 6;
    localparam int KEMU_ST_PARITY = 7;

    // ==========================================================
    // reset values
    localparam logic [7:0] KEMU_BYTE_RST = 8'h00;
    localparam logic [31:0] KEMU_WORD_RST = 32'h0000_0000;
    localparam logic [23:0] KEMU_RSVD_RD = 24'h00_0000;

endpackage

// *** core/kemu_port_if.sv ***
// decoded legacy port events passed from the decoder to the register bank
// assumes all signals are single-cycle qualifiers in the clk domain
`timescale 1ns/1ps

interface kemu_port_if;
    logic wr_data_port;
    logic wr_cmd_port;
    logic rd_data_port;
    logic rd_cmd_port;
    logic [7:0] wr_byte;

    // ==========================================================
    // decoder drives, register bank listens
    modport src (
        output wr_data_port,
        output wr_cmd_port,
        output rd_data_port,
        output rd_cmd_port,
        output wr_byte
    );
    modport dst (
        input wr_data_port,
        input wr_cmd_port,
        input rd_data_port,
        input rd_cmd_port,
        input wr_byte
    );
endinterface

// *** core/kemu_port_decode.sv ***
// decodes host i/o accesses to the two legacy keyboard ports
// assumes io strobes are synchronous one-cycle qualifiers
`timescale 1ns/1ps

module kemu_port_decode (
    // host i/o access
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [15:0] io_addr,
    input wire logic [7:0] io_wdata,
    // control
    input wire logic emulation_enable_bit,
    // decoded events
    kemu_port_if.src evt
);
    logic hit_data;
    logic hit_cmd;

    // ==========================================================
    // port match, gated by the enable so a disabled block sees nothing
    always_comb begin
        hit_data = emulation_enable_bit && (io_addr == kemu_pkg::KEMU_PORT_DATA); // see RULE20
        hit_cmd = emulation_enable_bit && (io_addr == kemu_pkg::KEMU_PORT_CMD); // see RULE20
        evt.wr_data_port = io_wr && hit_data;
        evt.wr_cmd_port = io_wr && hit_cmd;
        // a simultaneous write wins; reads never pair with writes
        evt.rd_data_port = io_rd && !io_wr && hit_data;
        evt.rd_cmd_port = io_rd && !io_wr && hit_cmd;
        evt.wr_byte = io_wdata;
    end
endmodule

// *** core/kemu_irq_gen.sv ***
// interrupt conditions derived from the emulation status and control bits
// assumes status inputs come straight from the register bank flops
`timescale 1ns/1ps

module kemu_irq_gen (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // control bits
    input wire logic emulation_enable_bit,
    input wire logic char_pending_enable,
    input wire logic legacy_irq_enable,
    // status bits
    input wire logic in_full,
    input wire logic out_full,
    input wire logic aux_full,
    // interrupt outputs
    output logic emu_irq_q,
    output logic keyboard_interrupt_line_q,
    output logic mouse_interrupt_line_q
);
    logic emu_irq_d;
    logic kbd_d;
    logic mouse_d;

    // ==========================================================
    // level conditions, registered once so outputs are glitch free
    always_comb begin
        emu_irq_d = (in_full && emulation_enable_bit) // see RULE10
                    || (!out_full && char_pending_enable); // see RULE11 see RULE23
        kbd_d = legacy_irq_enable && out_full && !aux_full; // see RULE13 see RULE14
        mouse_d = legacy_irq_enable && out_full && aux_full; // see RULE12 see RULE13
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            emu_irq_q <= 1'b0;
            keyboard_interrupt_line_q <= 1'b0;
            mouse_interrupt_line_q <= 1'b0;
        end else begin
            emu_irq_q <= emu_irq_d;
            keyboard_interrupt_line_q <= kbd_d;
            mouse_interrupt_line_q <= mouse_d;
        end
    end

    // ==========================================================
    // checks
    emu_irq_level_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE10
        (in_full && emulation_enable_bit) |=> emu_irq_q)
        else $error("emulation interrupt missing while input pending");
    char_pend_irq_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE11
        (!out_full && char_pending_enable) |=> emu_irq_q)
        else $error("emulation interrupt missing for character pending");
    mouse_line_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE12
        $past(legacy_irq_enable && out_full && aux_full) == mouse_interrupt_line_q)
        else $error("mouse line does not follow its condition");
    line_select_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE13
        !(keyboard_interrupt_line_q && mouse_interrupt_line_q)
            && (!$past(legacy_irq_enable && out_full) || keyboard_interrupt_line_q || mouse_interrupt_line_q))
        else $error("keyboard and mouse line selection wrong");
    kbd_line_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE14
        (legacy_irq_enable && out_full && !aux_full) |=> keyboard_interrupt_line_q)
        else $error("keyboard line missing");
endmodule

// *** tb/kemu_host_model.sv ***
// host processor model issuing legacy port writes and reads
// assumes the bench calls its tasks and the block answers one cycle later
`timescale 1ns/1ps

module kemu_host_model (
    // clock
    input wire logic clk,
    // legacy port access
    output logic io_wr,
    output logic io_rd,
    output logic [15:0] io_addr,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata_q
);
    // ==========================================================
    // idle values, address and data parked off any legal port
    initial begin
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_addr = 16'hffff;
        io_wdata = 8'h00;
    end

    // one-cycle write strobe, then address parked so no stale decode
    task automatic port_write(input logic [15:0] addr, input logic [7:0] data);
        @(posedge clk);
        io_wr <= 1'b1;
        io_addr <= addr;
        io_wdata <= data;
        @(posedge clk);
        io_wr <= 1'b0;
        io_addr <= 16'hffff;
        io_wdata <= ~data;
        #1; // let the block's flops settle before the caller checks
    endtask

    // read data is taken one cycle after the strobe, when it stands
    task automatic port_read(input logic [15:0] addr, output logic [7:0] data);
        @(posedge clk);
        io_rd <= 1'b1;
        io_addr <= addr;
        @(posedge clk);
        io_rd <= 1'b0;
        io_addr <= 16'hffff;
        #1;
        data = io_rdata_q;
    endtask
endmodule

// *** tb/kemu_regs_tb.sv ***
// self-checking bench for the keyboard emulation register block
// assumes the host model drives the ports and the bench drives operational access
`timescale 1ns/1ps

module kemu_regs_tb;
    // ==========================================================
    // signals
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic mm_wr = 1'b0;
    logic mm_rd = 1'b0;
    logic [11:0] mm_addr = 12'h000;
    logic [31:0] mm_wdata = 32'h0000_0000;
    logic [31:0] mm_rdata_q;
    logic en = 1'b0;
    logic cpe = 1'b0;
    logic irq_en = 1'b0;
    logic inh = 1'b0;
    logic io_wr, io_rd;
    logic [15:0] io_addr;
    logic [7:0] io_wdata, io_rdata_q, rb;
    logic [31:0] rw;
    logic flag_q, emu_irq_q, kb_q, ms_q;
    int mismatches = 0;
    int samples_checked = 0;

    // 25 MHz clock
    always #20 clk = ~clk;

    kemu_host_model host (.clk(clk), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_rdata_q(io_rdata_q));

    kemu_regs dut (.clk(clk), .sys_rst(sys_rst), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_rdata_q(io_rdata_q), .mm_wr(mm_wr), .mm_rd(mm_rd), .mm_addr(mm_addr),
        .mm_wdata(mm_wdata), .mm_rdata_q(mm_rdata_q), .emulation_enable_bit(en),
        .char_pending_enable(cpe), .legacy_irq_enable(irq_en), .keyboard_inhibit_state(inh),
        .gate_a20_sequence_flag_q(flag_q), .emu_irq_q(emu_irq_q),
        .keyboard_interrupt_line_q(kb_q), .mouse_interrupt_line_q(ms_q));

    // ==========================================================
    // compare and closing tasks
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ==========================================================
    // operational access, one-cycle strobes
    task automatic mm_write(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        mm_wr <= 1'b1;
        mm_addr <= a;
        mm_wdata <= d;
        @(posedge clk);
        mm_wr <= 1'b0;
        mm_wdata <= ~d;
        #1; // written state is settled when the task returns
    endtask

    task automatic mm_read(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        mm_rd <= 1'b1;
        mm_addr <= a;
        @(posedge clk);
        mm_rd <= 1'b0;
        #1;
        d = mm_rdata_q;
    endtask

    // irq outputs are registered one cycle behind their cause
    task automatic settle();
        @(posedge clk);
        #1;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset();
        mm_read(kemu_pkg::KEMU_OFF_INPUT, rw); check_val(rw, 32'h0);
        mm_read(kemu_pkg::KEMU_OFF_OUTPUT, rw); check_val(rw, 32'h0);
        mm_read(kemu_pkg::KEMU_OFF_STATUS, rw); check_val(rw, 32'h0);
        mm_read(12'h100, rw); check_val(rw, 32'h0);
        check_bit(emu_irq_q | kb_q | ms_q | flag_q, 1'b0);
    endtask

    task automatic t_cmd_write();
        host.port_write(kemu_pkg::KEMU_PORT_CMD, kemu_pkg::KEMU_CMD_GATE_A20);
        check_bit(flag_q, 1'b1);
        mm_read(kemu_pkg::KEMU_OFF_INPUT, rw); check_val(rw, 32'hd1);
        mm_read(kemu_pkg::KEMU_OFF_STATUS, rw); check_val(rw, 32'h1a);
        check_bit(emu_irq_q, 1'b1);
    endtask

    task automatic t_gate_data();
        mm_write(kemu_pkg::KEMU_OFF_STATUS, 32'h0);
        settle(); check_bit(emu_irq_q, 1'b0);
        check_bit(flag_q, 1'b1);
        host.port_write(kemu_pkg::KEMU_PORT_DATA, 8'h02);
        mm_read(kemu_pkg::KEMU_OFF_INPUT, rw); check_val(rw, 32'h02);
        mm_read(kemu_pkg::KEMU_OFF_STATUS, rw); check_val(rw, 32'h10);
        host.port_write(kemu_pkg::KEMU_PORT_CMD, 8'h20);
        check_bit(flag_q, 1'b0);
        mm_write(kemu_pkg::KEMU_OFF_STATUS, 32'h0);
        host.port_write(kemu_pkg::KEMU_PORT_DATA, 8'h55);
        mm_read(kemu_pkg::KEMU_OFF_STATUS, rw); check_val(rw, 32'h12);
    endtask

    task automatic t_output_irq();
        @(posedge clk); irq_en <= 1'b1;
        mm_write(kemu_pkg::KEMU_OFF_OUTPUT, 32'h5a);
        mm_write(kemu_pkg::KEMU_OFF_STATUS, 32'h01);
        settle(); check_bit(kb_q, 1'b1); check_bit(ms_q, 1'b0);
        mm_write(kemu_pkg::KEMU_OFF_STATUS, 32'h21);
        settle(); check_bit(ms_q, 1'b1); check_bit(kb_q, 1'b0);
        check_bit(emu_irq_q, 1'b0);
        host.port_read(kemu_pkg::KEMU_PORT_DATA, rb); check_val({24'h0, rb}, 32'h5a);
        mm_read(kemu_pkg::KEMU_OFF_STATUS, rw); check_val(rw, 32'h30);
        check_bit(ms_q, 1'b0);
        @(posedge clk); cpe <= 1'b1;
        settle(); settle(); check_bit(emu_irq_q, 1'b1);
        @(posedge clk); cpe <= 1'b0;
    endtask

    task automatic t_status_port();
        mm_write(kemu_pkg::KEMU_OFF_STATUS, 32'hc4);
        host.port_read(kemu_pkg::KEMU_PORT_CMD, rb); check_val({24'h0, rb}, 32'hd4);
        @(posedge clk); inh <= 1'b0;
        mm_read(kemu_pkg::KEMU_OFF_STATUS, rw); check_val(rw, 32'hc4);
        @(posedge clk); inh <= 1'b1;
    endtask

    task automatic t_disabled();
        @(posedge clk); en <= 1'b0;
        host.port_write(kemu_pkg::KEMU_PORT_DATA, 8'h99);
        host.port_read(kemu_pkg::KEMU_PORT_CMD, rb); check_val({24'h0, rb}, 32'h0);
        mm_read(kemu_pkg::KEMU_OFF_INPUT, rw); check_val(rw, 32'h55);
        @(posedge clk); en <= 1'b1;
    endtask

    task automatic t_input_word();
        mm_write(kemu_pkg::KEMU_OFF_INPUT, 32'hffff_ff33);
        mm_read(kemu_pkg::KEMU_OFF_INPUT, rw); check_val(rw, 32'h33);
        mm_read(kemu_pkg::KEMU_OFF_STATUS, rw); check_val(rw, 32'hd4);
    endtask

    // ==========================================================
    // main sequence, reset held for 8 cycles
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        @(posedge clk); en <= 1'b1; inh <= 1'b1;
        t_cmd_write();
        t_gate_data();
        t_output_irq();
        t_status_port();
        t_disabled();
        t_input_word();
        test_done();
    end

    // watchdog, far beyond the roughly 80 cycles the run needs
    initial begin
        #100000;
        mismatches++;
        test_done();
    end
endmodule
